/* src/clk_mgr_pkg.sv */
package clk_mgr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int REG_W = 8;
    localparam logic [2:0] OFF_DUTY = 3'h4;     // duty_delay_1x_program
    localparam logic [2:0] OFF_MODE = 3'h5;     // loop_mode_program
    localparam logic [2:0] OFF_ROUTE = 3'h6;    // output_source_select
    localparam logic [2:0] OFF_CTRL = 3'h7;     // manager_power_reset_control

    // Writable bit masks; everything else is reserved and reads zero
    localparam logic [7:0] MASK_DUTY = 8'hff;
    localparam logic [7:0] MASK_MODE = 8'h15;
    localparam logic [7:0] MASK_ROUTE = 8'hf0;
    localparam logic [7:0] MASK_CTRL = 8'hc7;

    // Values after reset
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_ROUTE = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DUTY_LO_SEL = 0;             // Selector for the lower half, [2:0]
    localparam int DUTY_HI_SEL = 3;             // Selector for the upper half, [5:3]
    localparam int DUTY_RANGE = 6;              // Master range, [7:6]
    localparam int MODE_PLL = 0;
    localparam int MODE_FB_DLINE = 2;
    localparam int MODE_2X = 4;
    localparam int ROUTE_FAST = 4;              // fast_io_clock source, [5:4]
    localparam int ROUTE_SYS = 6;               // System clock source, [7:6]
    localparam int CTRL_PWR = 0;
    localparam int CTRL_RST_ALL = 1;
    localparam int CTRL_RST_DLL = 2;
    localparam int CTRL_CFG_RUN = 6;
    localparam int CTRL_GSR_IMM = 7;

    // ------------------------------------------------------------
    // Source codes and duty / phase arithmetic
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_BYPASS = 2'h0;
    localparam logic [1:0] SRC_DLL = 2'h1;
    localparam logic [1:0] SRC_TAPPED = 2'h2;
    localparam logic [1:0] SRC_DIVIDED = 2'h3;
    localparam logic [1:0] RANGE_HALF = 2'h2;   // Ranges at or above this exceed 50%
    localparam logic [5:0] DUTY_STEPS_MAX = 6'h1f; // 31 steps of 3.125% = 96.875%
    localparam logic [4:0] PHASE_HALF = 5'h10;  // 16 delay steps = 180 degrees
    localparam logic [16:0] PHASE_STEP_CDEG = 17'h0_0465;  // 11.25 deg in 0.01 deg
    localparam logic [16:0] PHASE_FULL_CDEG = 17'h0_8ca0;  // 360 deg in 0.01 deg

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic we;                   // Write strobe, one cycle
        logic [ADDR_W-1:0] addr;    // Register index
        logic [REG_W-1:0] data;     // Write data
    } reg_wr_t;

    typedef struct packed {
        logic [1:0] fast_io_sel;    // fast_io_clock source
        logic [1:0] sys_sel;        // System clock source
    } clk_route_t;

endpackage

/* src/duty_phase_decoder.sv */
`timescale 1ns/10ps
module duty_phase_decoder (
    input wire logic [7:0] duty_reg,
    output logic [4:0] duty_steps,
    output logic signed [15:0] phase_cdeg
);

    // ------------------------------------------------------------
    // Duty / delay decode
    // ------------------------------------------------------------
    logic [1:0] range;          // Master range field
    logic [2:0] sel;            // Selector matching the chosen side of 50%
    logic [5:0] steps_raw;      // range*8 + sel + 1, may reach 32
    logic [16:0] prod;          // Delay steps times 11.25 degrees

    // Pick only the selector for the chosen half; the other is ignored
    always_comb begin
        range = duty_reg[clk_mgr_pkg::DUTY_RANGE +: 2];
        if (range < clk_mgr_pkg::RANGE_HALF) begin
            sel = duty_reg[clk_mgr_pkg::DUTY_LO_SEL +: 3];
        end else begin
            sel = duty_reg[clk_mgr_pkg::DUTY_HI_SEL +: 3];
        end
    end

    // Range times 8 steps plus selector plus one, capped at 31 steps
    always_comb begin
        steps_raw = {1'b0, range, 3'h0} + {3'h0, sel} + 6'h01;
        if (steps_raw > clk_mgr_pkg::DUTY_STEPS_MAX) begin
            duty_steps = clk_mgr_pkg::DUTY_STEPS_MAX[4:0];
        end else begin
            duty_steps = steps_raw[4:0];
        end
    end

    // ------------------------------------------------------------
    // Phase in hundredths of a degree
    // ------------------------------------------------------------
    always_comb begin
        prod = 17'(duty_steps * clk_mgr_pkg::PHASE_STEP_CDEG);
        if (duty_steps > clk_mgr_pkg::PHASE_HALF) begin
            phase_cdeg = 16'(prod - clk_mgr_pkg::PHASE_FULL_CDEG);
        end else begin
            phase_cdeg = prod[15:0];
        end
    end

endmodule

/* src/clock_manager_control_regs.sv */
// Function
// - Lower-half duty: range*25% plus (sel+1)*3.125%
// - Upper-half duty uses middle selector bits 5:3
// - Master range picks quarter of duty span
// - Unchosen selector is ignored
// - Mode bit 0: delay-locked or phase-locked
// - Mode bit 2: phase-locked feedback source
// - Mode bit 4: 1x or 2x, delay-locked only
// - Fast I/O clock source selector, four codes
// - System clock selector; code 11 reserved
// - Control bit 0 switches analog supply
// - Control bit 1 resets whole manager
// - Control bit 2 resets delay-locked generation only
// - Bit 6 clear: off until configuration done
// - Bit 6 set: run and load during configuration
// - Bit 7 makes manager immune to global reset
// - Phase equals steps*11.25, minus 360 above 16
`timescale 1ns/10ps
module clock_manager_control_regs #(
    parameter int REG_WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire clk_mgr_pkg::reg_wr_t sw_wr,
    input wire logic sw_rd_en,
    input wire logic [clk_mgr_pkg::ADDR_W-1:0] sw_rd_addr,
    output logic [REG_WIDTH-1:0] sw_rd_data,
    input wire clk_mgr_pkg::reg_wr_t cfg_wr,
    input wire logic config_done,
    input wire logic global_set_reset_n,
    input wire logic lock_raw,
    output logic analog_power_on,
    output logic out_bus_oe,
    output logic lock_out,
    output logic manager_reset,
    output logic dll_reset,
    output logic loop_is_pll,
    output logic fb_from_delay_line,
    output logic dll_2x,
    output clk_mgr_pkg::clk_route_t route,
    output logic [4:0] duty_steps,
    output logic signed [15:0] phase_cdeg
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (REG_WIDTH != clk_mgr_pkg::REG_W) begin : g_width_check
        $error("REG_WIDTH must equal the 8-bit register width");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] done_sync_ff;   // Configuration-done pin chain
    logic [2:0] gsr_sync_ff;    // Global set/reset pin chain
    logic [2:0] lock_sync_ff;   // Lock from analog loop
    logic done_f_ff;            // Filtered configuration-done
    logic gsr_n_f_ff;           // Filtered global set/reset, active low
    logic lock_f_ff;            // Filtered lock

    // Three-stage chains; a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_sync_ff <= 3'h0;
            gsr_sync_ff <= 3'h7;
            lock_sync_ff <= 3'h0;
        end else begin
            done_sync_ff <= {done_sync_ff[1:0], config_done};
            gsr_sync_ff <= {gsr_sync_ff[1:0], global_set_reset_n};
            lock_sync_ff <= {lock_sync_ff[1:0], lock_raw};
        end
    end

    // Filtered levels update only on agreement of the last two stages
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_f_ff <= 1'b0;
            gsr_n_f_ff <= 1'b1;
            lock_f_ff <= 1'b0;
        end else begin
            if (done_sync_ff[1] == done_sync_ff[2]) begin
                done_f_ff <= done_sync_ff[2];
            end
            if (gsr_sync_ff[1] == gsr_sync_ff[2]) begin
                gsr_n_f_ff <= gsr_sync_ff[2];
            end
            if (lock_sync_ff[1] == lock_sync_ff[2]) begin
                lock_f_ff <= lock_sync_ff[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] duty_ff;        // duty_delay_1x_program
    logic [7:0] mode_ff;        // loop_mode_program
    logic [7:0] route_ff;       // output_source_select
    logic [7:0] ctrl_ff;        // manager_power_reset_control
    clk_mgr_pkg::reg_wr_t wr;   // Write chosen for this cycle

    // Bitstream writes land only before done; software writes after
    always_comb begin
        wr = '0;
        if (!done_f_ff) begin
            wr = cfg_wr;
        end else begin
            wr = sw_wr;
        end
    end

    // Storage with reserved bits masked to zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            duty_ff <= clk_mgr_pkg::RST_DUTY;
            mode_ff <= clk_mgr_pkg::RST_MODE;
            route_ff <= clk_mgr_pkg::RST_ROUTE;
            ctrl_ff <= clk_mgr_pkg::RST_CTRL;
        end else if (wr.we) begin
            unique case (wr.addr)
                clk_mgr_pkg::OFF_DUTY: begin
                    duty_ff <= wr.data & clk_mgr_pkg::MASK_DUTY;
                end
                clk_mgr_pkg::OFF_MODE: begin
                    mode_ff <= wr.data & clk_mgr_pkg::MASK_MODE;
                end
                clk_mgr_pkg::OFF_ROUTE: begin
                    route_ff <= wr.data & clk_mgr_pkg::MASK_ROUTE;
                end
                clk_mgr_pkg::OFF_CTRL: begin
                    ctrl_ff <= wr.data & clk_mgr_pkg::MASK_CTRL;
                end
                default: begin
                    // Unmapped index; write dropped
                end
            endcase
        end
    end

    // Registered read port; unmapped indices read zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sw_rd_data <= '0;
        end else if (sw_rd_en) begin
            unique case (sw_rd_addr)
                clk_mgr_pkg::OFF_DUTY: sw_rd_data <= duty_ff;
                clk_mgr_pkg::OFF_MODE: sw_rd_data <= mode_ff;
                clk_mgr_pkg::OFF_ROUTE: sw_rd_data <= route_ff;
                clk_mgr_pkg::OFF_CTRL: sw_rd_data <= ctrl_ff;
                default: sw_rd_data <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Power, bus enable and lock gating
    // ------------------------------------------------------------
    logic may_run;              // Manager allowed to operate now

    always_comb begin
        may_run = done_f_ff | ctrl_ff[clk_mgr_pkg::CTRL_CFG_RUN];
    end

    // Held off during configuration unless early operation is enabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            analog_power_on <= 1'b0;
            out_bus_oe <= 1'b0;
            lock_out <= 1'b0;
        end else begin
            analog_power_on <= may_run & ctrl_ff[clk_mgr_pkg::CTRL_PWR];
            out_bus_oe <= may_run;
            lock_out <= may_run & lock_f_ff;
        end
    end

    // ------------------------------------------------------------
    // Reset generation
    // ------------------------------------------------------------
    logic gsr_hit;              // Global reset that reaches the manager

    always_comb begin
        gsr_hit = ~gsr_n_f_ff & ~ctrl_ff[clk_mgr_pkg::CTRL_GSR_IMM];
    end

    // Whole-manager reset implies generation reset as well
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            manager_reset <= 1'b1;
            dll_reset <= 1'b1;
        end else begin
            manager_reset <= ctrl_ff[clk_mgr_pkg::CTRL_RST_ALL] | gsr_hit;
            dll_reset <= ctrl_ff[clk_mgr_pkg::CTRL_RST_ALL] | gsr_hit
                | ctrl_ff[clk_mgr_pkg::CTRL_RST_DLL];
        end
    end

    // ------------------------------------------------------------
    // Mode and routing outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            loop_is_pll <= 1'b0;
            fb_from_delay_line <= 1'b0;
            dll_2x <= 1'b0;
        end else begin
            loop_is_pll <= mode_ff[clk_mgr_pkg::MODE_PLL];
            fb_from_delay_line <= mode_ff[clk_mgr_pkg::MODE_PLL]
                & mode_ff[clk_mgr_pkg::MODE_FB_DLINE];
            dll_2x <= ~mode_ff[clk_mgr_pkg::MODE_PLL]
                & mode_ff[clk_mgr_pkg::MODE_2X];
        end
    end

    // Reserved system source code falls back to bypass
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            route <= '0;
        end else begin
            route.fast_io_sel <= route_ff[clk_mgr_pkg::ROUTE_FAST +: 2];
            if (route_ff[clk_mgr_pkg::ROUTE_SYS +: 2] == clk_mgr_pkg::SRC_DIVIDED) begin
                route.sys_sel <= clk_mgr_pkg::SRC_BYPASS;
            end else begin
                route.sys_sel <= route_ff[clk_mgr_pkg::ROUTE_SYS +: 2];
            end
        end
    end

    // ------------------------------------------------------------
    // Duty and phase decode
    // ------------------------------------------------------------
    logic [4:0] steps_c;            // Decoded duty steps
    logic signed [15:0] phase_c;    // Decoded phase

    duty_phase_decoder duty_phase_decoder_inst (
        .duty_reg(duty_ff),
        .duty_steps(steps_c),
        .phase_cdeg(phase_c)
    );

    // Registered decode results
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            duty_steps <= 5'h00;
            phase_cdeg <= 16'sh0000;
        end else begin
            duty_steps <= steps_c;
            phase_cdeg <= phase_c;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_cfg_gate_off: assert property (@(posedge clk) disable iff (!rst_n)
        (!done_f_ff && !ctrl_ff[6]) |=> (!analog_power_on && !out_bus_oe && !lock_out))
        else $error("manager not held off during configuration");

    a_power_follow: assert property (@(posedge clk) disable iff (!rst_n)
        may_run |=> (analog_power_on == $past(ctrl_ff[0])))
        else $error("analog supply does not follow control bit 0");

    a_cfg_run_early: assert property (@(posedge clk) disable iff (!rst_n)
        (!done_f_ff && ctrl_ff[6]) |=> out_bus_oe)
        else $error("early operation not allowed during configuration");

    a_reset_all: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_ff[1] |=> (manager_reset && dll_reset))
        else $error("manager reset missing");

    a_dll_reset_only: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_ff[2] && !ctrl_ff[1] && !gsr_hit) |=> (dll_reset && !manager_reset))
        else $error("generation reset wrong");

    a_gsr_immune: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_ff[7] && !ctrl_ff[1]) |=> !manager_reset)
        else $error("global reset reached immune manager");

    a_gsr_normal: assert property (@(posedge clk) disable iff (!rst_n)
        (!gsr_n_f_ff && !ctrl_ff[7]) |=> manager_reset)
        else $error("global reset ignored");

    a_mode_ignore: assert property (@(posedge clk) disable iff (!rst_n)
        !loop_is_pll |-> !fb_from_delay_line)
        else $error("feedback select active in delay-locked mode");

    a_2x_ignore: assert property (@(posedge clk) disable iff (!rst_n)
        loop_is_pll |-> !dll_2x)
        else $error("2x select active in phase-locked mode");

    a_sys_reserved: assert property (@(posedge clk) disable iff (!rst_n)
        route.sys_sel != clk_mgr_pkg::SRC_DIVIDED)
        else $error("reserved system source routed");

    a_mode_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
        (sw_rd_en && sw_rd_addr == clk_mgr_pkg::OFF_MODE) |=> (sw_rd_data[7:5] == 3'h0
            && sw_rd_data[3] == 1'b0 && sw_rd_data[1] == 1'b0))
        else $error("reserved mode bits read nonzero");

    a_phase_sign: assert property (@(posedge clk) disable iff (!rst_n)
        (duty_steps > 5'h10) |-> (phase_cdeg < 0))
        else $error("phase not wrapped above 16 steps");

    a_duty_low: assert property (@(posedge clk) disable iff (!rst_n)
        (duty_ff[7:6] == 2'h1) |=> (duty_steps == 5'(5'h09 + $past(duty_ff[2:0]))))
        else $error("lower-half duty decode wrong");

    c_pll_mode: cover property (@(posedge clk) disable iff (!rst_n) loop_is_pll);
    c_early_power: cover property (@(posedge clk) disable iff (!rst_n)
        !done_f_ff && analog_power_on);
    c_gsr_immune: cover property (@(posedge clk) disable iff (!rst_n)
        !gsr_n_f_ff && ctrl_ff[7]);
    c_phase_neg: cover property (@(posedge clk) disable iff (!rst_n) phase_cdeg < 0);

endmodule

/* bench/clock_manager_control_regs_tb.sv */
`timescale 1ns/10ps
module clock_manager_control_regs_tb;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    clk_mgr_pkg::reg_wr_t sw_wr = '0;       // Software write port
    clk_mgr_pkg::reg_wr_t cfg_wr = '0;      // Bitstream write port
    logic sw_rd_en = 1'b0;
    logic [2:0] sw_rd_addr = 3'h0;
    logic config_done = 1'b0;
    logic global_set_reset_n = 1'b1;
    logic lock_raw = 1'b0;
    logic [7:0] sw_rd_data;
    logic analog_power_on, out_bus_oe, lock_out, manager_reset, dll_reset;
    logic loop_is_pll, fb_from_delay_line, dll_2x;
    clk_mgr_pkg::clk_route_t route;
    logic [4:0] duty_steps;
    logic signed [15:0] phase_cdeg;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    // Row: index, write data, readback, {pll,fb,2x}, route, steps, phase
    typedef struct packed {
        logic [2:0] a;
        logic [7:0] d;
        logic [7:0] rb;
        logic [2:0] m;
        logic [3:0] r;
        logic [4:0] st;
        logic [15:0] ph;
    } row_t;
    row_t rows [18] = '{
        '{3'h4, 8'h3a, 8'h3a, 3'h0, 4'h0, 5'h03, 16'h0d2f},
        '{3'h4, 8'h44, 8'h44, 3'h0, 4'h0, 5'h0d, 16'h3921},
        '{3'h4, 8'h7c, 8'h7c, 3'h0, 4'h0, 5'h0d, 16'h3921},
        '{3'h4, 8'h4f, 8'h4f, 3'h0, 4'h0, 5'h10, 16'h4650},
        '{3'h4, 8'h87, 8'h87, 3'h0, 4'h0, 5'h11, 16'hbe15},
        '{3'h4, 8'hf0, 8'hf0, 3'h0, 4'h0, 5'h1f, 16'hfb9b},
        '{3'h4, 8'hf8, 8'hf8, 3'h0, 4'h0, 5'h1f, 16'hfb9b},
        '{3'h4, 8'hc0, 8'hc0, 3'h0, 4'h0, 5'h19, 16'he13d},
        '{3'h5, 8'h15, 8'h15, 3'h6, 4'h0, 5'h19, 16'he13d},
        '{3'h5, 8'hff, 8'h15, 3'h6, 4'h0, 5'h19, 16'he13d},
        '{3'h5, 8'h14, 8'h14, 3'h1, 4'h0, 5'h19, 16'he13d},
        '{3'h5, 8'h04, 8'h04, 3'h0, 4'h0, 5'h19, 16'he13d},
        '{3'h6, 8'h5f, 8'h50, 3'h0, 4'h5, 5'h19, 16'he13d},
        '{3'h6, 8'ha0, 8'ha0, 3'h0, 4'ha, 5'h19, 16'he13d},
        '{3'h6, 8'h30, 8'h30, 3'h0, 4'hc, 5'h19, 16'he13d},
        '{3'h6, 8'hc0, 8'hc0, 3'h0, 4'h0, 5'h19, 16'he13d},
        '{3'h3, 8'hff, 8'h00, 3'h0, 4'h0, 5'h19, 16'he13d},
        '{3'h0, 8'haa, 8'h00, 3'h0, 4'h0, 5'h19, 16'he13d}
    };

    // ----------------------------------------
    // Clock, timeout and design instance
    // ----------------------------------------
    // 200 MHz clock
    always #2.5 clk = ~clk;

    // Cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            end_of_test();
        end
    end

    clock_manager_control_regs clock_manager_control_regs_inst (
        .clk(clk), .rst_n(rst_n), .sw_wr(sw_wr), .sw_rd_en(sw_rd_en),
        .sw_rd_addr(sw_rd_addr), .sw_rd_data(sw_rd_data), .cfg_wr(cfg_wr),
        .config_done(config_done), .global_set_reset_n(global_set_reset_n),
        .lock_raw(lock_raw), .analog_power_on(analog_power_on),
        .out_bus_oe(out_bus_oe), .lock_out(lock_out),
        .manager_reset(manager_reset), .dll_reset(dll_reset),
        .loop_is_pll(loop_is_pll), .fb_from_delay_line(fb_from_delay_line),
        .dll_2x(dll_2x), .route(route), .duty_steps(duty_steps),
        .phase_cdeg(phase_cdeg)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // Compare one value, report a mismatch
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Wait n edges, then settle
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One write on either port; derived outputs settle two edges later
    task automatic wr(input bit cfg, input logic [2:0] a, input logic [7:0] d);
        if (cfg) cfg_wr = '{1'b1, a, d};
        else sw_wr = '{1'b1, a, d};
        cyc(1);
        cfg_wr = '0;
        sw_wr = '0;
        cyc(1);
    endtask

    // One read, data checked the cycle after the strobe; an idle edge follows
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        sw_rd_en = 1'b1;
        sw_rd_addr = a;
        cyc(1);
        sw_rd_en = 1'b0;
        chk(sw_rd_data, exp);
        cyc(1);
    endtask

    // Print counts and verdict
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        cyc(6);
        chk({manager_reset, dll_reset, analog_power_on, out_bus_oe}, 16'h000c);
        rst_n = 1'b1;
        cyc(2);
        chk({loop_is_pll, route}, 16'h0000);
        rd(3'h7, 8'h00);
        // Configuration phase: bitstream loads, bit 6 lets the manager run
        lock_raw = 1'b1;
        wr(1'b1, 3'h7, 8'h41);
        cyc(4);
        chk({analog_power_on, out_bus_oe, lock_out}, 16'h0007);
        wr(1'b0, 3'h7, 8'h00);
        rd(3'h7, 8'h41);
        wr(1'b1, 3'h7, 8'h01);
        chk({analog_power_on, out_bus_oe, lock_out}, 16'h0000);
        config_done = 1'b1;
        cyc(6);
        chk({analog_power_on, out_bus_oe, lock_out}, 16'h0007);
        wr(1'b1, 3'h7, 8'h00);
        rd(3'h7, 8'h01);
        // Ordinary register cases
        foreach (rows[i]) begin
            wr(1'b0, rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].rb);
            chk({loop_is_pll, fb_from_delay_line, dll_2x}, rows[i].m);
            chk(route, rows[i].r);
            chk(duty_steps, rows[i].st);
            chk(phase_cdeg, rows[i].ph);
        end
        // Supply switch and reset bits
        lock_raw = 1'b0;
        cyc(5);
        chk({analog_power_on, lock_out, manager_reset, dll_reset}, 16'h0008);
        wr(1'b0, 3'h7, 8'h02);
        chk({analog_power_on, manager_reset, dll_reset}, 16'h0003);
        wr(1'b0, 3'h7, 8'h04);
        chk({manager_reset, dll_reset}, 16'h0001);
        rd(3'h4, 8'hc0);
        wr(1'b0, 3'h7, 8'h38);
        rd(3'h7, 8'h00);
        // Global set/reset, then immunity to it
        wr(1'b0, 3'h7, 8'h01);
        global_set_reset_n = 1'b0;
        cyc(6);
        chk({manager_reset, dll_reset}, 16'h0003);
        rd(3'h4, 8'hc0);
        wr(1'b0, 3'h7, 8'h81);
        chk({manager_reset, dll_reset, analog_power_on}, 16'h0001);
        global_set_reset_n = 1'b1;
        cyc(6);
        // Reset in mid-run clears the duty, mode and route registers
        rst_n = 1'b0;
        cyc(2);
        chk({manager_reset, dll_reset, analog_power_on}, 16'h0006);
        rst_n = 1'b1;
        cyc(2);
        rd(3'h4, 8'h00);
        rd(3'h5, 8'h00);
        rd(3'h6, 8'h00);
        end_of_test();
    end
endmodule
